/* dcsp_pkg.sv */
/*
 * Shared constants for the dual channel state gated PWM block.
 * Assumes a single 10 MHz clock and synchronous active high reset.
 */
package dcsp_pkg;
    localparam int CNT_W = 32;
    localparam logic [31:0] PERIOD_RESET = 32'h0000_0FA0;
    localparam logic [31:0] DUTY_RESET = 32'h0000_07D0;
    localparam logic [31:0] COUNT_RESET = 32'h0000_0000;
    localparam logic WAVE_RESET = 1'b0;
endpackage

/* dcsp_decoder.sv */
/*
 * State decoder: turns the two direction state bits into opening, closing and either flags.
 * Assumes the state bits come from logic on the same clock.
 */
`timescale 1ns/1ps
module dcsp_decoder (
    input wire logic s0_i,
    input wire logic s1_i,
    output logic opening_o,
    output logic closing_o,
    output logic active_o
);
    import dcsp_pkg::*;
    assign opening_o = s0_i & ~s1_i;
    assign closing_o = ~s0_i & s1_i;
    assign active_o = opening_o | closing_o;
endmodule

/* dcsp_pwm.sv */
/*
 * Down-counting PWM whose waveform is steered to an opening or closing output.
 * Assumes direction state bits, the transition pulse and the period and duty values
 * arrive from logic on clock_i; period and duty may change at any time.
 */
`timescale 1ns/1ps
// What this block does
// - Waveform bit clears when the period counter is at zero while the decoder reports opening or closing.
// - Waveform bit sets when the counter equals the duty match value, unless the zero clear fires in the same cycle.
// - Zero reloads the period value unless a transition pulse arrives in the same cycle; defaults are 4000 period and 2000 duty.
// - In opening state the waveform drives the opening output, closing output low.
// - In closing state the waveform drives the closing output, opening output low.
// - Period and duty values stay writable while the counter runs.
// - Counter counts down only while the decoder reports opening or closing.
// - A transition pulse into opening or closing resets the counter.
// - Decoder flags opening only, closing only, and either of the two.
module dcsp_pwm #(
    parameter int WIDTH = dcsp_pkg::CNT_W
) (
    input wire logic clock_i,
    input wire logic rst_i,
    input wire logic state_s0_i,
    input wire logic state_s1_i,
    input wire logic transition_i,
    input wire logic [WIDTH-1:0] period_load_i,
    input wire logic [WIDTH-1:0] duty_match_i,
    output logic opening_pwm_o,
    output logic closing_pwm_o,
    output logic [WIDTH-1:0] count_o,
    output logic zero_event_o,
    output logic duty_match_event_o
);
    import dcsp_pkg::*;

    initial begin
        if (WIDTH < 2 || WIDTH > 32) begin
            $error("dcsp_pwm: WIDTH must be 2 to 32");
        end
    end

    logic opening;
    logic closing;
    logic count_enable;
    logic [WIDTH-1:0] count;
    logic wave;
    logic zero_event;
    logic duty_match_event;

    dcsp_decoder u_state_decoder (
        .s0_i(state_s0_i),
        .s1_i(state_s1_i),
        .opening_o(opening),
        .closing_o(closing),
        .active_o(count_enable)
    );

    // Events are qualified by the enable so an idle counter sitting at zero does not keep firing.
    assign zero_event = count_enable && (count == '0);
    assign duty_match_event = count_enable && (count == duty_match_i);

    // Duty is compared live each cycle and period is taken at each zero reload, so software can retune without halting.
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            count <= COUNT_RESET[WIDTH-1:0];
        end else if (transition_i) begin
            count <= COUNT_RESET[WIDTH-1:0];
        end else if (zero_event) begin
            count <= period_load_i;
        end else if (count_enable) begin
            count <= count - 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            wave <= WAVE_RESET;
        end else if (zero_event) begin
            wave <= 1'b0;
        end else if (duty_match_event) begin
            wave <= 1'b1;
        end
    end

    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            opening_pwm_o <= 1'b0;
            closing_pwm_o <= 1'b0;
        end else begin
            opening_pwm_o <= wave & opening;
            closing_pwm_o <= wave & closing;
        end
    end

    assign count_o = count;
    assign zero_event_o = zero_event;
    assign duty_match_event_o = duty_match_event;

    zero_clears_a: assert property (@(posedge clock_i) disable iff (rst_i)
        zero_event && !transition_i |=> !wave)
        else $error("wave not low after zero event");
    match_sets_a: assert property (@(posedge clock_i) disable iff (rst_i)
        duty_match_event && !zero_event |=> wave)
        else $error("wave not high after duty match");
    zero_reload_a: assert property (@(posedge clock_i) disable iff (rst_i)
        zero_event && !transition_i |=> count == $past(period_load_i))
        else $error("counter did not reload period");
    opening_route_a: assert property (@(posedge clock_i) disable iff (rst_i)
        opening |=> opening_pwm_o == $past(wave) && !closing_pwm_o)
        else $error("opening routing wrong");
    closing_route_a: assert property (@(posedge clock_i) disable iff (rst_i)
        closing |=> closing_pwm_o == $past(wave) && !opening_pwm_o)
        else $error("closing routing wrong");
    idle_hold_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !count_enable && !transition_i |=> $stable(count))
        else $error("counter moved while disabled");
    count_down_a: assert property (@(posedge clock_i) disable iff (rst_i)
        count_enable && !transition_i && count != '0 |=> count == $past(count) - 1'b1)
        else $error("counter did not count down");
    transition_reset_a: assert property (@(posedge clock_i) disable iff (rst_i)
        transition_i |=> count == '0)
        else $error("transition did not reset counter");
    decode_excl_a: assert property (@(posedge clock_i) disable iff (rst_i)
        !(opening && closing) && (count_enable == (state_s0_i ^ state_s1_i)))
        else $error("decoder flags inconsistent");
    clear_priority_a: assert property (@(posedge clock_i) disable iff (rst_i)
        zero_event && duty_match_event |=> !wave)
        else $error("set beat clear on coincidence");

    opening_pulse_c: cover property (@(posedge clock_i) disable iff (rst_i) $rose(opening_pwm_o));
    closing_pulse_c: cover property (@(posedge clock_i) disable iff (rst_i) $rose(closing_pwm_o));
    reload_c: cover property (@(posedge clock_i) disable iff (rst_i) zero_event ##1 count_enable);
    coincide_c: cover property (@(posedge clock_i) disable iff (rst_i) zero_event && duty_match_event);
endmodule

/* dcsp_pin_xbar.sv */
/* Pin crossbar model at the far side of the PWM block: routes the two waveforms to two pins.
 * Assumes pins follow the outputs with no delay and no inversion. */
`timescale 1ns/1ps
module dcsp_pin_xbar (
    input wire logic opening_i,
    input wire logic closing_i,
    output logic pin_a_o,
    output logic pin_b_o
);
    assign pin_a_o = opening_i;
    assign pin_b_o = closing_i;
endmodule

/* tb.sv */
/* Self-checking bench for dcsp_pwm with an integer model compared every cycle.
 * Assumes the pin crossbar model passes both outputs straight through. */
`timescale 1ns/1ps
module tb;
    import dcsp_pkg::*;
    logic clock_i = 0, rst_i = 1, s0 = 0, s1 = 0, tr = 0;
    logic [31:0] per = PERIOD_RESET, duty = DUTY_RESET, cnt;
    logic op, cl, ze, me, pa, pb;
    int errors = 0, total_checks = 0, m_cnt = 0, m_wave = 0, m_op = 0, m_cl = 0;
    always #50 clock_i = ~clock_i;
    dcsp_pwm dut_u (.clock_i(clock_i), .rst_i(rst_i), .state_s0_i(s0), .state_s1_i(s1), .transition_i(tr),
        .period_load_i(per), .duty_match_i(duty), .opening_pwm_o(op), .closing_pwm_o(cl), .count_o(cnt),
        .zero_event_o(ze), .duty_match_event_o(me));
    dcsp_pin_xbar pins_u (.opening_i(op), .closing_i(cl), .pin_a_o(pa), .pin_b_o(pb));
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic conclude();
        if (errors == 0 && total_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // The model reads only inputs that settled well before this edge.
    always @(posedge clock_i) begin : model
        int z, m;
        z = (s0 ^ s1) && m_cnt == per - per + 0;
        m = (s0 ^ s1) && m_cnt == int'(duty);
        if (rst_i) begin
            {m_cnt, m_wave, m_op, m_cl} = '0;
        end else begin
            m_op = m_wave && s0 && !s1;
            m_cl = m_wave && !s0 && s1;
            m_wave = z ? 0 : (m ? 1 : m_wave);
            m_cnt = tr ? 0 : (z ? int'(per) : ((s0 ^ s1) ? m_cnt - 1 : m_cnt));
        end
    end
    always @(negedge clock_i) begin
        if (!rst_i) begin
            check(cnt, m_cnt);
            check(32'(ze), 32'((s0 ^ s1) && m_cnt == 0));
            check(32'(me), 32'((s0 ^ s1) && m_cnt == int'(duty)));
            check(32'(pa), m_op);
            check(32'(pb), m_cl);
        end
    end
    initial begin
        void'($urandom(32'h9861E918));
        repeat (20) @(posedge clock_i);
        #1 rst_i = 0;
        s0 = 1;
        tr = 1;
        @(posedge clock_i);
        #1 tr = 0;
        repeat (9000) @(posedge clock_i);
        // Period and duty change live, often without a transition, and duty may equal zero or the period.
        repeat (60) begin
            #1 {s0, s1} = 2'($urandom);
            per = 32'($urandom % 16);
            duty = 32'($urandom % (per + 2));
            tr = 1'($urandom % 2);
            @(posedge clock_i);
            #1 tr = 0;
            repeat ($urandom % 40) @(posedge clock_i);
        end
        conclude();
    end
    initial begin
        repeat (20000) @(posedge clock_i);
        errors++;
        conclude();
    end
endmodule
